// ==== include/fsw_pkg.sv ====
// Shared constants and types for the flash status and write-protect block
package fsw_pkg;
    localparam int STATUS_W = 24;
    localparam int NV_W = 12;

    // Status word bit positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_SIZE_LO = 2;
    localparam int BIT_MODE_LOWER = 7;
    localparam int BIT_MODE_UPPER = 8;
    localparam int BIT_LANES = 9;
    localparam int BIT_PRG_PAUSE = 10;
    localparam int BIT_LOCK_LO = 11;
    localparam int BIT_COMPL = 14;
    localparam int BIT_ERS_PAUSE = 15;
    localparam int BIT_FAST = 20;
    localparam int HIGH_BYTE_BASE = 8;

    // Serial opcodes
    localparam logic [7:0] OPC_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_LATCH_CLR = 8'h04;
    localparam logic [7:0] OPC_RD_LOW = 8'h05;
    localparam logic [7:0] OPC_RD_MID = 8'h35;
    localparam logic [7:0] OPC_RD_TOP = 8'h15;
    localparam logic [7:0] OPC_STATUS_WR = 8'h01;
    localparam logic [7:0] OPC_PAGE_WR = 8'h02;
    localparam logic [7:0] OPC_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] OPC_BLK32_WIPE = 8'h52;
    localparam logic [7:0] OPC_BLK64_WIPE = 8'hd8;
    localparam logic [7:0] OPC_CHIP_WIPE_A = 8'h60;
    localparam logic [7:0] OPC_CHIP_WIPE_B = 8'hc7;
    localparam logic [7:0] OPC_PAUSE = 8'h75;
    localparam logic [7:0] OPC_RESUME = 8'h7a;
    localparam logic [7:0] OPC_RST_ARM = 8'h66;
    localparam logic [7:0] OPC_RST_GO = 8'h99;

    // Bytes per frame, opcode included, and last bit index of a byte
    localparam logic [2:0] LEN_OPC_ONLY = 3'h1;
    localparam logic [2:0] LEN_SW_SHORT = 3'h2;
    localparam logic [2:0] LEN_SW_LONG = 3'h3;
    localparam logic [2:0] LEN_ADDR = 3'h4;
    localparam logic [2:0] LEN_PAGE_MIN = 3'h5;
    localparam logic [2:0] LEN_MAX = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Array geometry, 17 bits so the full size fits
    localparam logic [16:0] ARR_SIZE = 17'h10000;
    localparam logic [16:0] SZ_PAGE = 17'h00100;
    localparam logic [16:0] SZ_4K = 17'h01000;
    localparam logic [16:0] SZ_8K = 17'h02000;
    localparam logic [16:0] SZ_16K = 17'h04000;
    localparam logic [16:0] SZ_32K = 17'h08000;

    typedef enum logic [2:0] {
        FSW_OP_NONE = 3'b000,
        FSW_OP_PAGE = 3'b001,
        FSW_OP_SECTOR = 3'b010,
        FSW_OP_BLK32 = 3'b011,
        FSW_OP_BLK64 = 3'b100,
        FSW_OP_CHIP = 3'b101
    } fsw_op_kind_t;

    typedef enum logic [2:0] {
        FR_IDLE = 3'b000,
        FR_OPC = 3'b001,
        FR_BODY = 3'b010,
        FR_READ = 3'b011
    } fsw_frame_t;

    typedef struct packed {
        logic valid;
        fsw_op_kind_t kind;
        logic [23:0] addr;
    } fsw_arr_op_t;

    typedef struct packed {
        logic protect_mode_upper;
        logic protect_mode_lower;
        logic protect_complement;
        logic [2:0] secure_area_lock;
        logic four_lane_enable;
        logic [4:0] protect_size;
    } fsw_nv_t;
endpackage

// ==== verilog/fsw_sync.sv ====
// Two-flop synchroniser for pin inputs
module fsw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_r <= '1;
            sync_out <= '1;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ==== verilog/fsw_region.sv ====
// Shielded-region decode and range check for program and erase
module fsw_region (
    input wire logic [4:0] protect_size,
    input wire logic protect_complement,
    input wire fsw_pkg::fsw_op_kind_t op_kind,
    input wire logic [15:0] op_addr,
    output logic shielded,
    output logic chip_ok
);
    import fsw_pkg::*;

    logic code_none;
    logic code_all;
    logic [16:0] part_size;
    logic [16:0] reg_lo;
    logic [16:0] reg_hi;
    logic [16:0] op_size;
    logic [16:0] op_lo;
    logic [16:0] op_hi;
    logic empty;
    logic full;

    always_comb begin
        code_none = 1'b0;
        code_all = 1'b0;
        part_size = SZ_4K;
        if (!protect_size[4]) begin
            code_none = (protect_size[1:0] == 2'h0);
            code_all = !code_none;
        end else begin
            case (protect_size[2:0])
                3'h0: code_none = 1'b1;
                3'h1: part_size = SZ_4K;
                3'h2: part_size = SZ_8K;
                3'h3: part_size = SZ_16K;
                3'h7: code_all = 1'b1;
                default: part_size = SZ_32K;
            endcase
        end
    end

    // Complement swaps the shielded and open parts of the array
    assign empty = protect_complement ? code_all : code_none;
    assign full = protect_complement ? code_none : code_all;

    always_comb begin
        // Side bit picks the end; complement shields the rest instead
        if (!protect_size[3]) begin
            reg_lo = protect_complement ? 17'h0 : ARR_SIZE - part_size;
            reg_hi = protect_complement ? ARR_SIZE - part_size - 17'h1 : ARR_SIZE - 17'h1;
        end else begin
            reg_lo = protect_complement ? part_size : 17'h0;
            reg_hi = protect_complement ? ARR_SIZE - 17'h1 : part_size - 17'h1;
        end
    end

    always_comb begin
        case (op_kind)
            FSW_OP_PAGE: op_size = SZ_PAGE;
            FSW_OP_SECTOR: op_size = SZ_4K;
            FSW_OP_BLK32: op_size = SZ_32K;
            default: op_size = ARR_SIZE;
        endcase
    end

    assign op_lo = {1'b0, op_addr} & ~(op_size - 17'h1);
    assign op_hi = op_lo + op_size - 17'h1;
    // Any overlap at all refuses the whole operation
    assign shielded = full || (!empty && !(op_hi < reg_lo || op_lo > reg_hi));
    assign chip_ok = (protect_size[2:0] == 3'h0 && !protect_complement)
        || (protect_size[2:0] == 3'h7 && protect_complement);
endmodule

// ==== verilog/fsw_top.sv ====
// Serial flash status word, write latch and array write protection
// Summary of operation
// - Hold a 24-bit status word with the documented flag positions.
// - Bit 0 reads 1 while program, erase or status write runs.
// - Bit 1 mirrors write latch; clear latch refuses writes, programs, erases.
// - Protect-size bits 6..2 are non-volatile, changed only by status write.
// - Shield selected region against page program, sector and block erase.
// - Protect-size bits are writable only outside hardware-protected mode.
// - Full erase runs only for low size bits 000/cmp0 or 111/cmp1.
// - Protect mode 00: status write allowed once latch is set.
// - Protect mode 01 with guard pin low: status word locked.
// - Protect mode 01 with guard pin high: write allowed after latch set.
// - Protect mode 10 locks until power cycle, which returns mode 00.
// - Protect mode 11 refuses every status write permanently.
// - Four-lane enable 0 keeps guard and pause pin functions; 1 frees them.
// - Three one-time lock bits, settable singly, make secure areas read-only.
// - Non-volatile complement bit 14 joins size bits in region choice.
// - Size code decode: none, all, or 4K..32K at top or bottom.
// - Complement set shields exactly the part left open otherwise.
// - Program or erase touching shielded region is ignored entirely.
// - Suspend sets paused flags; resume, soft reset, power cycle clear them.
// - Read-only fast flag shows high-performance mode, default 0.
module fsw_top #(
    parameter int STATUS_WR_CYC = 64,
    parameter int PROG_CYC = 256,
    parameter int ERASE_CYC = 1024
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic write_guard_n,
    input wire logic link_pause_n,
    input wire logic fast_mode,
    input wire fsw_pkg::fsw_nv_t nv_init,
    output logic so,
    output logic so_oe,
    output logic four_lane_enable,
    output logic [2:0] secure_area_lock,
    output logic write_cycle_busy,
    output fsw_pkg::fsw_arr_op_t arr_op,
    output fsw_pkg::fsw_nv_t nv_image
);
    import fsw_pkg::*;

    localparam int MAX_CYC = (ERASE_CYC > PROG_CYC) ?
        ((ERASE_CYC > STATUS_WR_CYC) ? ERASE_CYC : STATUS_WR_CYC) :
        ((PROG_CYC > STATUS_WR_CYC) ? PROG_CYC : STATUS_WR_CYC);
    localparam int CNT_W = $clog2(MAX_CYC + 1);

    if (STATUS_WR_CYC < 1 || PROG_CYC < 1 || ERASE_CYC < 1) begin : g_bad_cyc
        $error("fsw_top: busy cycle counts must be at least one");
    end

    // Pin inputs, all from outside the clock domain
    logic [4:0] pins_s;
    logic sclk_s;
    logic cs_s;
    logic si_s;
    logic guard_s;
    logic pause_s;

    fsw_sync #(.WIDTH(5)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({sclk, cs_n, si, write_guard_n, link_pause_n}),
        .sync_out(pins_s)
    );
    assign {sclk_s, cs_s, si_s, guard_s, pause_s} = pins_s;

    // Control and status state
    fsw_nv_t nv_r;
    logic wel_r;
    logic busy_r;
    logic paused_r;
    logic erase_paused_flag_r;
    logic program_paused_flag_r;
    logic fast_r;
    logic rst_arm_r;
    fsw_op_kind_t busy_kind_r;
    logic [CNT_W-1:0] busy_cnt_r;

    // Link state
    fsw_frame_t st_r;
    logic sclk_d_r;
    logic cs_d_r;
    logic [7:0] shift_r;
    logic [2:0] bit_cnt_r;
    logic [2:0] byte_cnt_r;
    logic [7:0] opc_r;
    logic [23:0] addr_r;
    logic [7:0] data0_r;
    logic [7:0] data1_r;
    logic [7:0] rd_hold_r;

    // Pause pin only stalls the link while it has its control role
    wire link_held = !nv_r.four_lane_enable && !pause_s;
    wire guard_eff = nv_r.four_lane_enable || guard_s;
    wire sclk_rise = sclk_s && !sclk_d_r && !cs_s && !link_held;
    wire sclk_fall = !sclk_s && sclk_d_r && !cs_s && !link_held;
    wire cs_fall = !cs_s && cs_d_r;
    wire cs_rise = cs_s && !cs_d_r;
    wire byte_done = sclk_rise && (bit_cnt_r == BIT_LAST);
    wire [7:0] in_byte = {shift_r[6:0], si_s};

    // Reserved positions are hard zeros
    wire [STATUS_W-1:0] status_word = {3'h0, fast_r, 4'h0, erase_paused_flag_r,
        nv_r.protect_complement, nv_r.secure_area_lock, program_paused_flag_r,
        nv_r.four_lane_enable, nv_r.protect_mode_upper, nv_r.protect_mode_lower,
        nv_r.protect_size, wel_r, busy_r && !paused_r};

    wire is_rd_opc = (in_byte == OPC_RD_LOW) || (in_byte == OPC_RD_MID)
        || (in_byte == OPC_RD_TOP);
    wire [7:0] rd_sel = (opc_r == OPC_RD_TOP) ? status_word[23:16] :
        (opc_r == OPC_RD_MID) ? status_word[15:8] : status_word[7:0];
    wire [7:0] rd_first = (in_byte == OPC_RD_TOP) ? status_word[23:16] :
        (in_byte == OPC_RD_MID) ? status_word[15:8] : status_word[7:0];

    // Command end only counts on a whole byte
    wire cmd_end = cs_rise && (st_r == FR_BODY) && (bit_cnt_r == 3'h0);
    wire len1 = (byte_cnt_r == LEN_OPC_ONLY);
    wire len4 = (byte_cnt_r == LEN_ADDR);
    wire idle_ok = !busy_r;
    wire c_set = cmd_end && len1 && (opc_r == OPC_LATCH_SET) && idle_ok;
    wire c_clr = cmd_end && len1 && (opc_r == OPC_LATCH_CLR) && idle_ok;
    wire c_sw = cmd_end && (opc_r == OPC_STATUS_WR)
        && (byte_cnt_r == LEN_SW_SHORT || byte_cnt_r == LEN_SW_LONG);
    wire c_pp = cmd_end && (opc_r == OPC_PAGE_WR) && (byte_cnt_r >= LEN_PAGE_MIN);
    wire c_se = cmd_end && len4 && (opc_r == OPC_SECTOR_WIPE);
    wire c_b32 = cmd_end && len4 && (opc_r == OPC_BLK32_WIPE);
    wire c_b64 = cmd_end && len4 && (opc_r == OPC_BLK64_WIPE);
    wire c_ce = cmd_end && len1
        && (opc_r == OPC_CHIP_WIPE_A || opc_r == OPC_CHIP_WIPE_B);
    wire c_pause = cmd_end && len1 && (opc_r == OPC_PAUSE);
    wire c_resume = cmd_end && len1 && (opc_r == OPC_RESUME);
    wire c_arm = cmd_end && len1 && (opc_r == OPC_RST_ARM);
    wire c_go = cmd_end && len1 && (opc_r == OPC_RST_GO) && rst_arm_r;

    fsw_op_kind_t req_kind;
    assign req_kind = c_pp ? FSW_OP_PAGE : c_se ? FSW_OP_SECTOR :
        c_b32 ? FSW_OP_BLK32 : c_b64 ? FSW_OP_BLK64 :
        c_ce ? FSW_OP_CHIP : FSW_OP_NONE;

    logic shielded;
    logic chip_ok;

    fsw_region u_region (
        .protect_size(nv_r.protect_size),
        .protect_complement(nv_r.protect_complement),
        .op_kind(req_kind),
        .op_addr(addr_r[15:0]),
        .shielded(shielded),
        .chip_ok(chip_ok)
    );

    // Status write permission by protect mode
    wire [1:0] mode = {nv_r.protect_mode_upper, nv_r.protect_mode_lower};
    wire sw_mode_ok = (mode == 2'b00)
        || (mode == 2'b01 && guard_eff);
    // Modes 10 and 11 never pass; 10 is undone only by rst
    wire sw_go = c_sw && idle_ok && wel_r && sw_mode_ok;
    wire arr_req = c_pp || c_se || c_b32 || c_b64;
    wire arr_go = arr_req && idle_ok && wel_r && !shielded;
    wire ce_go = c_ce && idle_ok && wel_r && chip_ok;
    wire op_go = arr_go || ce_go;

    // New non-volatile image from a status write
    fsw_nv_t nv_wr;
    always_comb begin
        nv_wr = nv_r;
        nv_wr.protect_size = data0_r[BIT_SIZE_LO +: 5];
        nv_wr.protect_mode_lower = data0_r[BIT_MODE_LOWER];
        if (byte_cnt_r == LEN_SW_LONG) begin
            nv_wr.protect_mode_upper = data1_r[BIT_MODE_UPPER - HIGH_BYTE_BASE];
            nv_wr.four_lane_enable = data1_r[BIT_LANES - HIGH_BYTE_BASE];
            nv_wr.protect_complement = data1_r[BIT_COMPL - HIGH_BYTE_BASE];
            // Lock bits only ever go from 0 to 1
            nv_wr.secure_area_lock = nv_r.secure_area_lock
                | data1_r[BIT_LOCK_LO - HIGH_BYTE_BASE +: 3];
        end
    end

    // Link framing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= FR_IDLE;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            shift_r <= 8'h0;
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 3'h0;
            opc_r <= 8'h0;
            addr_r <= 24'h0;
            data0_r <= 8'h0;
            data1_r <= 8'h0;
            rd_hold_r <= 8'h0;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_s;
            if (cs_fall) begin
                st_r <= FR_OPC;
                bit_cnt_r <= 3'h0;
                byte_cnt_r <= 3'h0;
            end else if (cs_s) begin
                st_r <= FR_IDLE;
            end else if (sclk_rise) begin
                shift_r <= in_byte;
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (byte_done) begin
                    if (byte_cnt_r != LEN_MAX) begin
                        byte_cnt_r <= byte_cnt_r + 3'h1;
                    end
                    case (st_r)
                        FR_OPC: begin
                            opc_r <= in_byte;
                            st_r <= is_rd_opc ? FR_READ : FR_BODY;
                            rd_hold_r <= rd_first;
                        end
                        FR_BODY: begin
                            if (byte_cnt_r == LEN_OPC_ONLY) begin
                                addr_r[23:16] <= in_byte;
                                data0_r <= in_byte;
                            end
                            if (byte_cnt_r == LEN_SW_SHORT) begin
                                addr_r[15:8] <= in_byte;
                                data1_r <= in_byte;
                            end
                            if (byte_cnt_r == LEN_SW_LONG) begin
                                addr_r[7:0] <= in_byte;
                            end
                        end
                        // Continuous read refreshes the byte each round
                        FR_READ: rd_hold_r <= rd_sel;
                        default: st_r <= FR_IDLE;
                    endcase
                end
            end
        end
    end

    // Serial out, shifted on falling clock, MSB first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            so <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so_oe <= (st_r == FR_READ) && !cs_s;
            if (cs_s) begin
                so <= 1'b0;
            end else if (sclk_fall && st_r == FR_READ) begin
                so <= rd_hold_r[BIT_LAST - bit_cnt_r];
            end
        end
    end

    // Write latch, busy timer, suspend flags
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wel_r <= 1'b0;
            busy_r <= 1'b0;
            paused_r <= 1'b0;
            busy_kind_r <= FSW_OP_NONE;
            busy_cnt_r <= '0;
            erase_paused_flag_r <= 1'b0;
            program_paused_flag_r <= 1'b0;
            rst_arm_r <= 1'b0;
            fast_r <= 1'b0;
            write_cycle_busy <= 1'b0;
        end else begin
            fast_r <= fast_mode;
            write_cycle_busy <= status_word[BIT_BUSY];
            if (cmd_end) begin
                rst_arm_r <= c_arm;
            end
            if (c_go) begin
                wel_r <= 1'b0;
                busy_r <= 1'b0;
                paused_r <= 1'b0;
                erase_paused_flag_r <= 1'b0;
                program_paused_flag_r <= 1'b0;
            end else if (sw_go || op_go) begin
                wel_r <= 1'b0;
                busy_r <= 1'b1;
                busy_kind_r <= sw_go ? FSW_OP_NONE : req_kind;
                busy_cnt_r <= sw_go ? CNT_W'(STATUS_WR_CYC) :
                    c_pp ? CNT_W'(PROG_CYC) : CNT_W'(ERASE_CYC);
            end else begin
                if (c_set) begin
                    wel_r <= 1'b1;
                end
                if (c_clr) begin
                    wel_r <= 1'b0;
                end
                // Status writes cannot be suspended
                if (c_pause && busy_r && !paused_r && busy_kind_r != FSW_OP_NONE) begin
                    paused_r <= 1'b1;
                    if (busy_kind_r == FSW_OP_PAGE) begin
                        program_paused_flag_r <= 1'b1;
                    end else begin
                        erase_paused_flag_r <= 1'b1;
                    end
                end else if (c_resume && paused_r) begin
                    paused_r <= 1'b0;
                    erase_paused_flag_r <= 1'b0;
                    program_paused_flag_r <= 1'b0;
                end else if (busy_r && !paused_r) begin
                    if (busy_cnt_r <= CNT_W'(1)) begin
                        busy_r <= 1'b0;
                    end else begin
                        busy_cnt_r <= busy_cnt_r - CNT_W'(1);
                    end
                end
            end
        end
    end

    // Non-volatile image; rst stands for a power cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nv_r <= nv_init;
            if (nv_init.protect_mode_upper && !nv_init.protect_mode_lower) begin
                nv_r.protect_mode_upper <= 1'b0;
            end
            arr_op <= '0;
        end else begin
            if (sw_go) begin
                nv_r <= nv_wr;
            end
            arr_op.valid <= op_go;
            if (op_go) begin
                arr_op.kind <= req_kind;
                arr_op.addr <= addr_r;
            end
        end
    end

    assign four_lane_enable = nv_r.four_lane_enable;
    assign secure_area_lock = nv_r.secure_area_lock;
    assign nv_image = nv_r;
endmodule

// ==== verification/fsw_top_properties.sv ====
// Port checks for the status and write-protect block
module fsw_chk
    import fsw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic write_guard_n,
    input wire fsw_pkg::fsw_nv_t nv_init,
    input wire logic four_lane_enable,
    input wire logic [2:0] secure_area_lock,
    input wire logic write_cycle_busy,
    input wire fsw_pkg::fsw_arr_op_t arr_op,
    input wire fsw_pkg::fsw_nv_t nv_image
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Guard pin passes two sync flops, so it must sit low a while
    sequence s_guard_low;
        !write_guard_n [*4];
    endsequence
    sequence s_busy_run;
        write_cycle_busy [*8];
    endsequence
    property p_busy_op;
        arr_op.valid |-> ##[0:3] s_busy_run;
    endproperty
    property p_no_op_busy;
        $past(write_cycle_busy, 4) && write_cycle_busy |-> !arr_op.valid;
    endproperty
    property p_chip;
        arr_op.valid && arr_op.kind == FSW_OP_CHIP |->
            nv_image.protect_size[2:0] == (nv_image.protect_complement ? 3'h7 : 3'h0);
    endproperty
    property p_lock_keep;
        !$past(rst) |-> (secure_area_lock & $past(secure_area_lock)) == $past(secure_area_lock);
    endproperty
    property p_size_wr;
        !$past(rst) && $changed(nv_image.protect_size) |-> ##[0:3] write_cycle_busy;
    endproperty
    property p_mode_upper;
        !$past(rst) && $past(nv_image.protect_mode_upper) |-> $stable(nv_image);
    endproperty
    property p_guard;
        s_guard_low ##0 nv_image.protect_mode_lower && !four_lane_enable |=> $stable(nv_image);
    endproperty
    property p_boot_mode;
        $past(rst) && $past(nv_init.protect_mode_upper && !nv_init.protect_mode_lower) |->
            !nv_image.protect_mode_upper && !nv_image.protect_mode_lower;
    endproperty
    a_busy_op: assert property (p_busy_op) else $error("no busy after accept");
    a_no_op_busy: assert property (p_no_op_busy) else $error("accept while busy");
    a_chip: assert property (p_chip) else $error("chip erase on bad code");
    a_lock_keep: assert property (p_lock_keep) else $error("lock bit cleared");
    a_size_wr: assert property (p_size_wr) else $error("size change without write");
    a_mode_upper: assert property (p_mode_upper) else $error("locked word written");
    a_guard: assert property (p_guard) else $error("write with guard low");
    a_boot_mode: assert property (p_boot_mode) else $error("mode kept over boot");
endmodule
bind fsw_top fsw_chk u_chk (.ref_clk(ref_clk), .rst(rst), .write_guard_n(write_guard_n),
    .nv_init(nv_init), .four_lane_enable(four_lane_enable),
    .secure_area_lock(secure_area_lock), .write_cycle_busy(write_cycle_busy),
    .arr_op(arr_op), .nv_image(nv_image));

// ==== verification/fsw_host.sv ====
// Serial host model, mode 0 frames, first bit most significant
module fsw_host (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic ref_clk,
    input wire logic so
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end
    // Six reference cycles per half gives the 48 ns serial period
    task automatic half();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask
    task automatic xfer(input int n, input logic [55:0] d, output logic [7:0] rd);
        rd = 8'h00;
        half();
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = d[55-i];
            half();
            sclk = 1'b1;
            rd = {rd[6:0], so};
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        si = ~si;
        repeat (4) half();
    endtask
endmodule

// ==== verification/tb_top.sv ====
// Directed bench for the status and write-protect block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fsw_pkg::*;
    logic ref_clk, rst, sclk, cs_n, si, so, so_oe, guard_n, pause_n, fast, lanes, busy;
    logic [2:0] lock;
    fsw_nv_t nv_seed, nv_image;
    fsw_arr_op_t arr_op, last_op;
    int fail_count = 0;
    int n_tests = 0;
    int oe_cyc = 0;
    fsw_top #(.STATUS_WR_CYC(8), .PROG_CYC(16), .ERASE_CYC(1000)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
        .write_guard_n(guard_n), .link_pause_n(pause_n), .fast_mode(fast), .so_oe(so_oe),
        .nv_init(nv_seed), .four_lane_enable(lanes), .secure_area_lock(lock),
        .write_cycle_busy(busy), .arr_op(arr_op), .nv_image(nv_image));
    fsw_host u_host (.ref_clk(ref_clk), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (arr_op.valid)
            last_op <= arr_op;
    end
    always @(posedge ref_clk) begin
        if (so_oe)
            oe_cyc++;
    end
    task automatic chk(input string nm, input logic [27:0] exp, input logic [27:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic cmd(input int n, input logic [55:0] d);
        logic [7:0] got;
        u_host.xfer(n, d, got);
    endtask
    task automatic op1(input logic [7:0] opc);
        cmd(8, {opc, 48'h0});
    endtask
    task automatic rd(input logic [7:0] opc, input logic [7:0] exp);
        logic [7:0] got;
        int c0;
        c0 = oe_cyc;
        u_host.xfer(16, {opc, 48'h0}, got);
        chk("status", 28'(exp), 28'(got));
        chk("oe", 28'h1, 28'(oe_cyc > c0));
    endtask
    // Clearing the capture here makes every later op check self-contained
    task automatic wen();
        last_op = '0;
        op1(OPC_LATCH_SET);
    endtask
    task automatic sw(input logic [15:0] w);
        wen();
        cmd(24, {OPC_STATUS_WR, w, 32'h0});
    endtask
    task automatic pgm(input logic [7:0] opc, input int n, input logic [15:0] a);
        wen();
        cmd(n, {opc, 8'h00, a, 24'h0});
    endtask
    task automatic pwr(input fsw_nv_t s);
        @(posedge ref_clk);
        #1;
        nv_seed = s;
        rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        guard_n = 1'b1;
        pause_n = 1'b1;
        fast = 1'b0;
        nv_seed = '0;
        last_op = '0;
        pwr('0);
        cmd(9, {OPC_LATCH_SET, 48'h0});
        rd(OPC_RD_LOW, 8'h00);
        pause_n = 1'b0;
        op1(OPC_LATCH_SET);
        pause_n = 1'b1;
        rd(OPC_RD_LOW, 8'h00);
        cmd(16, {OPC_STATUS_WR, 8'h1c, 40'h0});
        rd(OPC_RD_LOW, 8'h00);
        wen();
        rd(OPC_RD_LOW, 8'h02);
        op1(OPC_LATCH_CLR);
        rd(OPC_RD_LOW, 8'h00);
        wen();
        cmd(16, {OPC_STATUS_WR, 8'h1c, 40'h0});
        rd(OPC_RD_LOW, 8'h1c);
        rd(OPC_RD_TOP, 8'h00);
        $display("test latch done");
        pgm(OPC_PAGE_WR, 40, 16'h0000);
        chk("op", 28'h0, last_op);
        wen();
        op1(OPC_CHIP_WIPE_A);
        chk("op", 28'h0, last_op);
        sw(16'h4400);
        pgm(OPC_BLK32_WIPE, 32, 16'h8000);
        chk("op", 28'h0, last_op);
        pgm(OPC_PAGE_WR, 40, 16'hf000);
        chk("op", 28'h0, last_op);
        pgm(OPC_PAGE_WR, 40, 16'hef00);
        chk("op", {1'b1, FSW_OP_PAGE, 24'h00ef00}, last_op);
        sw(16'h4440);
        rd(OPC_RD_MID, 8'h40);
        pgm(OPC_SECTOR_WIPE, 32, 16'he000);
        chk("op", 28'h0, last_op);
        pgm(OPC_PAGE_WR, 40, 16'hf000);
        chk("op", {1'b1, FSW_OP_PAGE, 24'h00f000}, last_op);
        $display("test region done");
        sw(16'h5c40);
        wen();
        op1(OPC_CHIP_WIPE_B);
        chk("kind", 28'(FSW_OP_CHIP), 28'(last_op.kind));
        op1(OPC_PAUSE);
        rd(OPC_RD_MID, 8'hc0);
        chk("busy", 28'h0, 28'(busy));
        op1(OPC_RESUME);
        rd(OPC_RD_MID, 8'h40);
        chk("busy", 28'h1, 28'(busy));
        op1(OPC_PAUSE);
        op1(OPC_RST_ARM);
        op1(OPC_RST_GO);
        rd(OPC_RD_MID, 8'h40);
        chk("busy", 28'h0, 28'(busy));
        $display("test erase done");
        sw(16'h8002);
        chk("lanes", 28'h1, 28'(lanes));
        pause_n = 1'b0;
        wen();
        rd(OPC_RD_LOW, 8'h82);
        pause_n = 1'b1;
        guard_n = 1'b0;
        sw(16'h8000);
        chk("lanes", 28'h0, 28'(lanes));
        sw(16'h0001);
        rd(OPC_RD_LOW, 8'h82);
        guard_n = 1'b1;
        sw(16'h0009);
        rd(OPC_RD_MID, 8'h09);
        chk("lock", 28'h1, 28'(lock));
        sw(16'h0000);
        rd(OPC_RD_MID, 8'h09);
        pwr(nv_image);
        rd(OPC_RD_MID, 8'h08);
        pwr(fsw_nv_t'(12'hc40));
        sw(16'h0002);
        rd(OPC_RD_LOW, 8'h82);
        fast = 1'b1;
        rd(OPC_RD_TOP, 8'h10);
        $display("test mode done");
        test_done();
    end
endmodule
